/* File: src/adc_seq_pkg.sv */
package adc_seq_pkg;

   // ---------------------------------------------------------------
   // register map (word per register, 16-bit data path)
   // ---------------------------------------------------------------
   localparam int             ADDR_W              = 3;
   localparam int             DATA_W              = 16;
   localparam logic [2:0]     OFS_CONTROL_STATUS  = 3'h0;
   localparam logic [2:0]     OFS_TRIGGER_CONTROL = 3'h1;
   localparam logic [2:0]     OFS_EDGE_SELECT     = 3'h2;
   localparam logic [2:0]     OFS_RESULT_BASE     = 3'h4;  // 4..7: result a..d

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int             BIT_END_FLAG        = 7;
   localparam int             BIT_IRQ_ENABLE      = 6;
   localparam int             BIT_GO              = 5;
   localparam int             BIT_SCAN            = 4;
   localparam int             BIT_SPEED           = 3;
   localparam int             BIT_TRIG_ENABLE     = 7;
   localparam int             BIT_EDGE_POLARITY   = 5;
   localparam int             RESULT_SHIFT        = 6;

   // ---------------------------------------------------------------
   // values after reset and fixed read values
   // ---------------------------------------------------------------
   localparam logic [7:0]     CSR_RESET           = 8'h00;
   localparam logic [5:0]     TRIG_RSVD_ONES      = 6'h3f;
   localparam logic [9:0]     RESULT_RESET        = 10'h000;
   localparam logic [15:0]    RDATA_RESET         = 16'h0000;

   // ---------------------------------------------------------------
   // conversion times, in states; one state is one core_clk cycle
   // ---------------------------------------------------------------
   localparam int             CYCLES_PER_STATE    = 1;
   localparam int             SLOW_FIRST_STATES   = 134;
   localparam int             FAST_FIRST_STATES   = 70;
   localparam int             SLOW_NEXT_STATES    = 128;
   localparam int             FAST_NEXT_STATES    = 66;
   localparam int             SLOW_FIRST_CYCLES   = SLOW_FIRST_STATES * CYCLES_PER_STATE;
   localparam int             FAST_FIRST_CYCLES   = FAST_FIRST_STATES * CYCLES_PER_STATE;
   localparam int             SLOW_NEXT_CYCLES    = SLOW_NEXT_STATES * CYCLES_PER_STATE;
   localparam int             FAST_NEXT_CYCLES    = FAST_NEXT_STATES * CYCLES_PER_STATE;
   localparam int             TIMER_W             = 8;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [0:0] {
      ST_IDLE    = 1'b0,
      ST_CONVERT = 1'b1
   } seq_state_t;

   typedef struct packed {
      logic       go;       // one-cycle start pulse to the analog core
      logic [2:0] channel;  // input to sample
   } conv_req_t;

   typedef struct packed {
      logic       done;     // one-cycle pulse, result valid
      logic [9:0] result;
   } conv_ans_t;

endpackage

/* File: src/adc_sequencer_control.sv */
`timescale 1ns/1ps
// Behaviour
// - single mode: end flag (csr bit 7) sets when the channel's conversion ends
// - scan mode: end flag sets after each full pass over the selected channels
// - end flag clears only by writing 0 after reading it as 1
// - interrupt request is high while end flag and enable bit 6 are both 1
// - writing 1 to go bit 5 starts conversion in the current mode and channels
// - single mode: go bit self-clears when the conversion ends, back to waiting
// - scan mode: conversions continue until go cleared by software, reset or standby
// - bit 4 selects mode: 0 single, 1 scan
// - bit 3 selects speed: 0 gives 134 states, 1 gives 70 states at most
// - single mode: channel bits 2..0 pick one input, 000 input 0 to 111 input 7
// - scan mode: bit 2 picks group, bits 1..0 give the last channel scanned
// - trigger enable (trigger reg bit 7) lets the chosen pin edge start conversion
// - trigger edge polarity comes from a bit in the edge select register
// - trigger reg bits 6..1 read as 1 and ignore writes
// - results stored left aligned in bits 15..6, low six bits read zero
// - scan passes start at the group's first input and restart there each pass
// - a qualifying trigger edge sets the go bit, then acts like a software start
// - scan conversions after the first take 128 states slow, 66 states fast
module adc_sequencer_control (
   input  wire logic                                core_clk,
   input  wire logic                                reset,
   input  wire logic [adc_seq_pkg::ADDR_W-1:0]      bus_addr,
   input  wire logic [adc_seq_pkg::DATA_W-1:0]      bus_wdata,
   input  wire logic                                bus_write,
   input  wire logic                                bus_read,
   output      logic [adc_seq_pkg::DATA_W-1:0]      bus_rdata,
   input  wire logic                                ext_trigger_pin,
   input  wire logic                                standby,
   output      adc_seq_pkg::conv_req_t              core_req,
   input  wire adc_seq_pkg::conv_ans_t              core_ans,
   output      logic                                conversion_end_irq
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic                                   conversion_end_flag;
   logic                                   end_irq_enable;
   logic                                   conversion_go;
   logic                                   scan_mode;
   logic                                   conversion_speed_select;
   logic [2:0]                             channel_sel;
   logic                                   ext_trigger_enable;
   logic                                   trig_rsvd_bit0;
   logic                                   trigger_edge_polarity;
   logic                                   flag_armed;
   logic                                   trig_prev;
   adc_seq_pkg::seq_state_t                state;
   logic [adc_seq_pkg::TIMER_W-1:0]        timer;
   logic [1:0]                             cur_ch;
   logic                                   done_seen;
   logic [9:0]                             results [4];

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   wire logic wr_csr   = bus_write && (bus_addr == adc_seq_pkg::OFS_CONTROL_STATUS);
   wire logic wr_trig  = bus_write && (bus_addr == adc_seq_pkg::OFS_TRIGGER_CONTROL);
   wire logic wr_edge  = bus_write && (bus_addr == adc_seq_pkg::OFS_EDGE_SELECT);
   wire logic rd_csr   = bus_read && (bus_addr == adc_seq_pkg::OFS_CONTROL_STATUS);
   wire logic wr_go    = wr_csr && bus_wdata[adc_seq_pkg::BIT_GO];
   wire logic wr_flag0 = wr_csr && !bus_wdata[adc_seq_pkg::BIT_END_FLAG];

   // a start write uses the mode, speed and channel written beside it, so
   // software may set go together with the fields it changes
   wire logic       sel_scan  = wr_csr ? bus_wdata[adc_seq_pkg::BIT_SCAN] : scan_mode;
   wire logic       sel_speed = wr_csr ? bus_wdata[adc_seq_pkg::BIT_SPEED] :
                                         conversion_speed_select;
   wire logic [2:0] sel_ch    = wr_csr ? bus_wdata[2:0] : channel_sel;

   // ---------------------------------------------------------------
   // trigger edge; pin is already synchronous to core_clk
   // ---------------------------------------------------------------
   wire logic rise_edge = ext_trigger_pin && !trig_prev;
   wire logic fall_edge = !ext_trigger_pin && trig_prev;
   wire logic pol_edge  = trigger_edge_polarity ? rise_edge : fall_edge;
   wire logic trig_start = ext_trigger_enable && pol_edge;

   // ---------------------------------------------------------------
   // conversion sequencing terms
   // ---------------------------------------------------------------
   wire logic converting = (state == adc_seq_pkg::ST_CONVERT);
   wire logic timer_zero = (timer == '0);
   wire logic conv_end   = converting && timer_zero && (done_seen || core_ans.done);
   wire logic last_ch    = (cur_ch == channel_sel[1:0]);
   wire logic pass_end   = conv_end && (!scan_mode || last_ch);

   // go bit: trigger and software set it; a csr write of 0, single mode end or standby clears it
   logic next_go;
   always_comb begin
      if (standby) begin
         next_go = 1'b0;
      end else if (trig_start || wr_go) begin
         next_go = 1'b1;
      end else if (wr_csr) begin
         next_go = 1'b0;
      end else if (conv_end && !scan_mode) begin
         next_go = 1'b0;
      end else begin
         next_go = conversion_go;
      end
   end

   // a launch opens every conversion: from idle, or straight after one ends
   wire logic launch = next_go && (!converting || conv_end);
   wire logic first  = !converting;

   // scan walks up from the group's first input; single uses the field as is
   wire logic [1:0] next_ch_lo =
      !sel_scan ? sel_ch[1:0] :
      (converting && !last_ch) ? 2'(cur_ch + 2'h1) : 2'h0;

   // first conversion uses the longest time, later scan ones the fixed time
   wire logic [adc_seq_pkg::TIMER_W-1:0] load_cycles =
      first ? (sel_speed ?
               adc_seq_pkg::TIMER_W'(adc_seq_pkg::FAST_FIRST_CYCLES - 1) :
               adc_seq_pkg::TIMER_W'(adc_seq_pkg::SLOW_FIRST_CYCLES - 1)) :
              (sel_speed ?
               adc_seq_pkg::TIMER_W'(adc_seq_pkg::FAST_NEXT_CYCLES - 1) :
               adc_seq_pkg::TIMER_W'(adc_seq_pkg::SLOW_NEXT_CYCLES - 1));

   // next state
   adc_seq_pkg::seq_state_t next_state;
   always_comb begin
      unique case (state)
         adc_seq_pkg::ST_IDLE: begin
            next_state = launch ? adc_seq_pkg::ST_CONVERT : adc_seq_pkg::ST_IDLE;
         end
         adc_seq_pkg::ST_CONVERT: begin
            next_state = next_go ? adc_seq_pkg::ST_CONVERT : adc_seq_pkg::ST_IDLE;
         end
      endcase
   end

   // end flag: hardware set wins over the software clear
   wire logic next_flag = pass_end ? 1'b1 :
                          (wr_flag0 && flag_armed) ? 1'b0 :
                          conversion_end_flag;
   wire logic next_ie   = wr_csr ? bus_wdata[adc_seq_pkg::BIT_IRQ_ENABLE] : end_irq_enable;

   // ---------------------------------------------------------------
   // read mux; unmapped addresses read zero
   // ---------------------------------------------------------------
   wire logic [7:0] csr_view = {conversion_end_flag, end_irq_enable, conversion_go,
                                scan_mode, conversion_speed_select, channel_sel};
   wire logic [7:0] trig_view = {ext_trigger_enable, adc_seq_pkg::TRIG_RSVD_ONES,
                                 trig_rsvd_bit0};
   wire logic [7:0] edge_view = 8'(trigger_edge_polarity) << adc_seq_pkg::BIT_EDGE_POLARITY;
   wire logic [15:0] result_view =
      {results[bus_addr[1:0]], 6'h00};
   wire logic [15:0] next_rdata =
      !bus_read ? adc_seq_pkg::RDATA_RESET :
      bus_addr[2] ? result_view :
      (bus_addr == adc_seq_pkg::OFS_CONTROL_STATUS)  ? {8'h00, csr_view}  :
      (bus_addr == adc_seq_pkg::OFS_TRIGGER_CONTROL) ? {8'h00, trig_view} :
      (bus_addr == adc_seq_pkg::OFS_EDGE_SELECT)     ? {8'h00, edge_view} :
      adc_seq_pkg::RDATA_RESET;

   // ---------------------------------------------------------------
   // control and status registers
   // ---------------------------------------------------------------
   // mode, speed and channel take effect at the next launch; changing them
   // mid-conversion is software's hazard, so no interlock is spent on it
   always_ff @(posedge core_clk) begin
      if (reset) begin
         {end_irq_enable, scan_mode, conversion_speed_select, channel_sel} <= '0;
      end else if (wr_csr) begin
         end_irq_enable          <= bus_wdata[adc_seq_pkg::BIT_IRQ_ENABLE];
         scan_mode               <= bus_wdata[adc_seq_pkg::BIT_SCAN];
         conversion_speed_select <= bus_wdata[adc_seq_pkg::BIT_SPEED];
         channel_sel             <= bus_wdata[2:0];
      end
   end

   // flag, arm, go and interrupt; irq is registered from the next values
   always_ff @(posedge core_clk) begin
      if (reset) begin
         conversion_end_flag <= 1'b0;
         flag_armed          <= 1'b0;
         conversion_go       <= 1'b0;
         conversion_end_irq  <= 1'b0;
      end else begin
         conversion_end_flag <= next_flag;
         flag_armed          <= rd_csr ? conversion_end_flag : (wr_csr ? 1'b0 : flag_armed);
         conversion_go       <= next_go;
         conversion_end_irq  <= next_flag && next_ie;
      end
   end

   // trigger control and edge select
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ext_trigger_enable    <= 1'b0;
         trig_rsvd_bit0        <= 1'b0;
         trigger_edge_polarity <= 1'b0;
         trig_prev             <= 1'b0;
      end else begin
         if (wr_trig) begin
            ext_trigger_enable <= bus_wdata[adc_seq_pkg::BIT_TRIG_ENABLE];
            trig_rsvd_bit0     <= bus_wdata[0];
         end
         if (wr_edge) begin
            trigger_edge_polarity <= bus_wdata[adc_seq_pkg::BIT_EDGE_POLARITY];
         end
         trig_prev <= ext_trigger_pin;
      end
   end

   // ---------------------------------------------------------------
   // sequencer and core request
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state     <= adc_seq_pkg::ST_IDLE;
         timer     <= '0;
         cur_ch    <= 2'h0;
         done_seen <= 1'b0;
         core_req  <= '0;
      end else begin
         state        <= next_state;
         core_req.go  <= launch;
         if (launch) begin
            timer            <= load_cycles;
            cur_ch           <= next_ch_lo;
            done_seen        <= 1'b0;
            core_req.channel <= {sel_ch[2], next_ch_lo};
         end else begin
            timer     <= timer_zero ? timer : adc_seq_pkg::TIMER_W'(timer - 1'b1);
            done_seen <= done_seen || (converting && core_ans.done);
         end
      end
   end

   // results: one register per position in the group, written on done
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_result
         always_ff @(posedge core_clk) begin
            if (reset) begin
               results[gi] <= adc_seq_pkg::RESULT_RESET;
            end else if (converting && core_ans.done && cur_ch == 2'(gi)) begin
               results[gi] <= core_ans.result;
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (reset) begin
         bus_rdata <= adc_seq_pkg::RDATA_RESET;
      end else begin
         bus_rdata <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   // helper: cycles since the last core start, and the expected length
   logic [adc_seq_pkg::TIMER_W-1:0] conv_len;
   logic [adc_seq_pkg::TIMER_W-1:0] exp_len;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         conv_len <= '0;
         exp_len  <= '0;
      end else begin
         conv_len <= core_req.go ? adc_seq_pkg::TIMER_W'(2) :
                     adc_seq_pkg::TIMER_W'(conv_len + 1'b1);
         if (launch) begin
            exp_len <= adc_seq_pkg::TIMER_W'(load_cycles + 1'b1);
         end
      end
   end

   sequence seq_read_flag_set;
      rd_csr && conversion_end_flag;
   endsequence

   sequence seq_launch_first;
      !converting && launch;
   endsequence

   chk_flag_single: assert property (@(posedge core_clk) disable iff (reset)
      conv_end && !scan_mode |=> conversion_end_flag)
      else $error("end flag not set after single conversion");

   chk_flag_scan: assert property (@(posedge core_clk) disable iff (reset)
      conv_end && scan_mode && !last_ch && !conversion_end_flag && !pass_end
      |=> !conversion_end_flag)
      else $error("end flag set before scan pass completed");

   chk_flag_clear: assert property (@(posedge core_clk) disable iff (reset)
      conversion_end_flag && !pass_end && !flag_armed |=> conversion_end_flag)
      else $error("end flag cleared without a prior read");

   chk_flag_armclr: assert property (@(posedge core_clk) disable iff (reset)
      seq_read_flag_set ##1 !wr_csr ##1 (wr_flag0 && !pass_end) |=> !conversion_end_flag)
      else $error("end flag not cleared by read then write 0");

   chk_irq_level: assert property (@(posedge core_clk) disable iff (reset)
      conversion_end_irq == ($past(next_flag) && $past(next_ie)) &&
      (conversion_end_irq == (conversion_end_flag && end_irq_enable)))
      else $error("interrupt request disagrees with flag and enable");

   chk_go_launch: assert property (@(posedge core_clk) disable iff (reset)
      wr_go && !standby && !converting |=> core_req.go && conversion_go)
      else $error("software start did not launch a conversion");

   chk_single_clear: assert property (@(posedge core_clk) disable iff (reset)
      conv_end && !scan_mode && !wr_go && !trig_start |=> !conversion_go && !converting)
      else $error("go bit not cleared after single conversion");

   chk_scan_continue: assert property (@(posedge core_clk) disable iff (reset)
      conv_end && scan_mode && !standby && !wr_csr |=> conversion_go && core_req.go)
      else $error("scan stopped without a clear");

   chk_trig_start: assert property (@(posedge core_clk) disable iff (reset)
      trig_start && !standby |=> conversion_go ##0 (converting [*1]))
      else $error("trigger edge did not start conversion");

   chk_first_time: assert property (@(posedge core_clk) disable iff (reset)
      seq_launch_first ##1 core_req.go |-> exp_len == (conversion_speed_select ?
      8'(adc_seq_pkg::FAST_FIRST_CYCLES) : 8'(adc_seq_pkg::SLOW_FIRST_CYCLES)))
      else $error("first conversion time wrong");

   chk_conv_length: assert property (@(posedge core_clk) disable iff (reset)
      conv_end && done_seen |-> conv_len == exp_len)
      else $error("conversion ended at the wrong cycle");

   chk_scan_restart: assert property (@(posedge core_clk) disable iff (reset)
      pass_end && scan_mode && next_go |=> core_req.go && core_req.channel[1:0] == 2'h0)
      else $error("scan pass did not restart at group start");

   chk_result_store: assert property (@(posedge core_clk) disable iff (reset)
      converting && core_ans.done |=> results[$past(cur_ch)] == $past(core_ans.result))
      else $error("result not stored on done");

   chk_trig_rsvd: assert property (@(posedge core_clk) disable iff (reset)
      bus_read && bus_addr == adc_seq_pkg::OFS_TRIGGER_CONTROL |=> bus_rdata[6:1] == 6'h3f)
      else $error("reserved trigger bits not read as ones");

endmodule

/* File: tb/adc_core_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// analog core stand-in
// ----------------------------------------
module adc_core_model (
   input  wire logic                   core_clk,
   input  wire logic                   reset,
   input  wire adc_seq_pkg::conv_req_t core_req,
   input  wire logic [7:0]             delay,
   output      adc_seq_pkg::conv_ans_t core_ans
);
   logic [7:0] left;
   logic [9:0] value;
   // result toggles outside done, so a stale sample cannot pass for a fresh one
   always_ff @(posedge core_clk) begin
      if (reset) begin
         left     <= 8'h00;
         value    <= 10'h000;
         core_ans <= '0;
      end else begin
         core_ans.done   <= (left == 8'h01);
         core_ans.result <= (left == 8'h01) ? value : ~core_ans.result;
         if (core_req.go) begin
            left  <= delay;
            value <= {7'h50, core_req.channel};
         end else if (left != 8'h00) begin
            left <= left - 8'h01;
         end
      end
   end
endmodule

/* File: tb/adc_sequencer_control_test.sv */
`timescale 1ns/1ps
module adc_sequencer_control_test;
   // ----------------------------------------
   // signals, rows are {csr written, irq expected}
   // ----------------------------------------
   logic                   core_clk = 1'b0;
   logic                   reset = 1'b1;
   logic [2:0]             bus_addr = 3'h0;
   logic [15:0]            bus_wdata = 16'h0000;
   logic                   bus_write = 1'b0;
   logic                   bus_read = 1'b0;
   logic [15:0]            bus_rdata;
   logic                   ext_trigger_pin = 1'b0;
   logic                   standby = 1'b0;
   logic [7:0]             core_delay = 8'h14;
   logic                   conversion_end_irq;
   logic                   last_irq;
   logic [7:0]             c;
   adc_seq_pkg::conv_req_t core_req;
   adc_seq_pkg::conv_ans_t core_ans;
   int                     error_cnt = 0;
   int                     tests_run = 0;
   int                     cyc = 0;
   int                     go_t[$];
   logic [2:0]             go_ch[$];
   logic [8:0]             rows [8] = '{9'h050, 9'h0c3, 9'h054, 9'h0c7,
                                        9'h0d9, 9'h04a, 9'h05c, 9'h0cf};
   initial begin
      forever #2 core_clk = ~core_clk;
   end
   adc_sequencer_control u_dut (
      .core_clk           (core_clk),
      .reset              (reset),
      .bus_addr           (bus_addr),
      .bus_wdata          (bus_wdata),
      .bus_write          (bus_write),
      .bus_read           (bus_read),
      .bus_rdata          (bus_rdata),
      .ext_trigger_pin    (ext_trigger_pin),
      .standby            (standby),
      .core_req           (core_req),
      .core_ans           (core_ans),
      .conversion_end_irq (conversion_end_irq)
   );
   adc_core_model u_core (
      .core_clk (core_clk),
      .reset    (reset),
      .core_req (core_req),
      .delay    (core_delay),
      .core_ans (core_ans)
   );
   // log every launch to the core, for channel order and spacing
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (core_req.go === 1'b1) begin
         go_t.push_back(cyc);
         go_ch.push_back(core_req.channel);
      end
   end
   // ----------------------------------------
   // bus tasks and checking
   // ----------------------------------------
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_write <= 1'b1;
      @(posedge core_clk);
      bus_write <= 1'b0;
   endtask
   // read data stands one cycle only, so it is taken mid-cycle
   task automatic rd(input logic [2:0] a, input logic [15:0] exp, input string what);
      bus_addr <= a;
      bus_read <= 1'b1;
      @(posedge core_clk);
      bus_read <= 1'b0;
      @(negedge core_clk);
      last_irq = conversion_end_irq;
      chk(what, bus_rdata, exp);
      @(posedge core_clk);
   endtask
   function automatic logic [15:0] done_of(input logic [7:0] v);
      return {8'h00, 1'b1, v[6], 1'b0, v[4:0]};
   endfunction
   task automatic summarize();
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      rd(3'h0, 16'h0000, "csr reset");
      rd(3'h1, 16'h007e, "trig reset");
      rd(3'h4, 16'h0000, "result reset");
      wr(3'h1, 16'h0000);
      @(posedge core_clk);
      wr(3'h3, 16'hffff);
      rd(3'h1, 16'h007e, "trig rsvd");
      rd(3'h3, 16'h0000, "unmapped");
      // single conversions; each start write also clears the flag read last row
      foreach (rows[i]) begin
         c = rows[i][8:1];
         core_delay <= 8'(20 + 5 * i);
         wr(3'h0, {8'h00, c});
         repeat (64) @(posedge core_clk);
         rd(3'h0, {8'h00, c}, "running");
         repeat (8) @(posedge core_clk);
         rd(3'h0, c[3] ? done_of(c) : {8'h00, c}, "speed");
         repeat (70) @(posedge core_clk);
         rd(3'h0, done_of(c), "end");
         chk("irq", {15'h0000, last_irq}, {15'h0000, rows[i][0]});
         rd({1'b1, c[1:0]}, 16'ha000 | {7'h00, c[2:0], 6'h00}, "result");
      end
      // a clear write without the read beforehand must not clear
      wr(3'h0, 16'h0028);
      repeat (80) @(posedge core_clk);
      wr(3'h0, 16'h0000);
      rd(3'h0, 16'h0080, "no arm");
      wr(3'h0, 16'h0000);
      rd(3'h0, 16'h0000, "armed clear");
      // scan of group 1 up to input 5, then standby stops it
      core_delay <= 8'h0a;
      go_t.delete();
      go_ch.delete();
      wr(3'h0, 16'h003d);
      repeat (190) @(posedge core_clk);
      rd(3'h0, 16'h00bd, "scan pass");
      chk("irq off", {15'h0000, last_irq}, 16'h0000);
      standby <= 1'b1;
      @(posedge core_clk);
      standby <= 1'b0;
      rd(3'h0, 16'h009d, "standby");
      chk("scan ch", {go_ch[0], go_ch[1], go_ch[2], 7'h00}, 16'h9600);
      chk("first gap", 16'(go_t[1] - go_t[0]), 16'h0046);
      chk("next gap", 16'(go_t[2] - go_t[1]), 16'h0042);
      // rising edge on the trigger pin starts a single conversion
      wr(3'h1, 16'h0080);
      @(posedge core_clk);
      wr(3'h2, 16'h0020);
      @(posedge core_clk);
      wr(3'h0, 16'h0009);
      rd(3'h1, 16'h00fe, "trig enable");
      ext_trigger_pin <= 1'b1;
      repeat (80) @(posedge core_clk);
      rd(3'h0, 16'h0089, "trigger start");
      rd(3'h5, 16'ha040, "trigger result");
      // falling edge starts once the polarity bit is cleared
      wr(3'h2, 16'h0000);
      @(posedge core_clk);
      wr(3'h0, 16'h000b);
      ext_trigger_pin <= 1'b0;
      repeat (80) @(posedge core_clk);
      rd(3'h0, 16'h008b, "fall start");
      rd(3'h7, 16'ha0c0, "fall result");
      // reset in mid scan returns registers and results to their reset values
      wr(3'h0, 16'h0030);
      repeat (20) @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      rd(3'h0, 16'h0000, "mid reset csr");
      rd(3'h1, 16'h007e, "mid reset trig");
      rd(3'h4, 16'h0000, "mid reset result");
      summarize();
   end
endmodule
